// [rtl/tag_arbiter.sv]
// session status, memory arbitration, field-detect output and watchdog of the tag
// ------------------------------------------------------------------
// Operation
// - set message_read_done after final block read; clear it when status is read
// - host ownership reserves memory for host; host clears it by writing 0
// - reader ownership flag shows memory reserved for reader; read-only, resets 0
// - buffer-ready-for-host set while SRAM holds data for the host
// - buffer-ready-for-reader set while SRAM holds data for the reader
// - write-error flag set on high-voltage failure; host clears by writing 0
// - busy flag high during EEPROM write; EEPROM access blocked meanwhile
// - field_present shows a detected field; read-only, resets 0
// - stretch byte reads zero above bit 0; bit 0 mirrors stretch_enable
// - assert field-detect on the selected event: field, first command, selection
// - release field-detect on selected event: field loss, halt, final block read
// - in pass-through, field-detect signals new reader data and reader consumption
// - watchdog expiry clears host ownership; host sees only the status change
// - 16-bit watchdog period, default 848h, from 0001h to FFFFh
// - watchdog starts when host communication begins
// - expiry during a host transaction clears ownership right after it ends
// - idle host keeping ownership loses it when the period ends
// - watchdog held reset without contact supply, or while only reader owns
// - low byte of watchdog count is its own session byte
// - host address mismatch deselects and clears host ownership
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tag_arbiter import tag_arb_pkg::*; (
   // system clock
   input wire logic clk_i,
   input wire logic srst_i,
   // link clock
   input wire logic rf_clk_i,
   input wire logic rf_srst_i,
   // pins
   input wire logic field_sense_i,
   input wire logic vcc_sense_i,
   output logic fd_o,
   output logic fd_oe_o,
   // configuration
   input wire cfg_t cfg_i,
   // host register port
   input wire host_reg_req_t host_req_i,
   output logic [7:0] host_rd_data_o,
   output logic host_rd_valid_o,
   // host session events
   input wire logic i2c_start_i,
   input wire logic i2c_busy_i,
   input wire logic i2c_nomatch_i,
   input wire logic host_access_i,
   input wire logic host_sram_written_i,
   input wire logic host_sram_read_i,
   // nonvolatile memory controller
   input wire logic nv_busy_i,
   input wire logic nv_hv_fail_i,
   output logic host_mem_grant_o,
   output logic reader_mem_grant_o,
   output logic host_nv_allow_o,
   output logic reader_nv_allow_o,
   // reader front end (link clock)
   input wire rf_evt_t rf_evt_i,
   input wire logic rf_rd_i,
   input wire logic [REG_AW-1:0] rf_rd_addr_i,
   output logic [7:0] rf_rd_data_o,
   output logic rf_rd_valid_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic field_s1;
      logic field_s2;
      logic field_q;
      logic vcc_s1;
      logic vcc_s2;
      logic msg_read;
      logic host_owns;
      logic reader_owns;
      logic ready_host;
      logic ready_reader;
      logic nv_err;
      logic [15:0] wdt;
      logic consumed;
      logic detect;
      logic [7:0] rd_data;
      logic rd_valid;
      logic [7:0] rf_hold;
      logic rf_ack_tgl;
   } core_t;

   typedef struct packed {
      logic [$bits(rf_evt_t)-1:0] evt_tgl;
      logic req_tgl;
      logic busy;
      logic [REG_AW-1:0] addr;
      logic [7:0] data;
      logic valid;
   } link_t;

   core_t st_ff;
   core_t nxt_st;
   link_t lk_ff;
   link_t nxt_lk;
   rf_evt_t ev;
   logic [$bits(rf_evt_t)-1:0] ev_pulse;
   logic rf_req_p;
   logic rf_ack_p;
   logic wdt_expired;
   logic wdt_run;
   logic host_status_rd;
   logic rf_status_rd;
   logic field_rise;
   logic field_fall;

   // ----------------------------------------------------------------
   // crossings between link and system clocks
   // ----------------------------------------------------------------
   toggle_sync #(.W($bits(rf_evt_t))) u_evt_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .tgl_i(lk_ff.evt_tgl),
      .pulse_o(ev_pulse)
   );

   toggle_sync #(.W(1)) u_req_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .tgl_i(lk_ff.req_tgl),
      .pulse_o(rf_req_p)
   );

   toggle_sync #(.W(1)) u_ack_sync (
      .clk_i(rf_clk_i),
      .srst_i(rf_srst_i),
      .tgl_i(st_ff.rf_ack_tgl),
      .pulse_o(rf_ack_p)
   );

   assign ev = rf_evt_t'(ev_pulse);

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   // held while unpowered or while only the reader owns memory
   assign wdt_run = st_ff.vcc_s2 && !(!st_ff.host_owns && st_ff.reader_owns);

   wdt_timer u_wdt (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .restart_i(i2c_start_i),
      .run_i(wdt_run),
      .limit_i(st_ff.wdt),
      .expired_o(wdt_expired)
   );

   // ----------------------------------------------------------------
   // register images
   // ----------------------------------------------------------------
   function automatic logic [7:0] status_byte(core_t s, logic busy);
      logic [7:0] b;
      b = '0;
      b[ST_MSG_READ] = s.msg_read;
      b[ST_HOST_OWNS] = s.host_owns;
      b[ST_READER_OWNS] = s.reader_owns;
      b[ST_READY_HOST] = s.ready_host;
      b[ST_READY_READER] = s.ready_reader;
      b[ST_NV_ERR] = s.nv_err;
      b[ST_NV_BUSY] = busy;
      b[ST_FIELD] = s.field_q;
      return b;
   endfunction

   function automatic logic [7:0] reg_image(core_t s, logic [REG_AW-1:0] a, logic busy, logic stretch);
      logic [7:0] b;
      b = '0;
      case (a)
         REG_WDT_LOW: b = s.wdt[7:0];
         REG_WDT_HIGH: b = s.wdt[15:8];
         REG_STRETCH: b[STRETCH_BIT] = stretch;
         REG_STATUS: b = status_byte(s, busy);
         default: b = '0;
      endcase
      return b;
   endfunction

   function automatic logic [7:0] merge(logic [7:0] old, logic [7:0] mask, logic [7:0] wdata);
      return (old & ~mask) | (wdata & mask);
   endfunction

   assign host_status_rd = host_req_i.rd && host_req_i.addr == REG_STATUS;
   assign rf_status_rd = rf_req_p && lk_ff.addr == REG_STATUS;
   assign field_rise = st_ff.field_s2 && !st_ff.field_q;
   assign field_fall = !st_ff.field_s2 && st_ff.field_q;

   // ----------------------------------------------------------------
   // system-clock logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.field_s1 = field_sense_i;
      nxt_st.field_s2 = st_ff.field_s1;
      nxt_st.field_q = st_ff.field_s2;
      nxt_st.vcc_s1 = vcc_sense_i;
      nxt_st.vcc_s2 = st_ff.vcc_s1;
      nxt_st.rd_valid = 1'b0;

      // register reads
      if (host_req_i.rd) begin
         nxt_st.rd_data = reg_image(st_ff, host_req_i.addr, nv_busy_i, cfg_i.stretch_enable);
         nxt_st.rd_valid = 1'b1;
      end
      // reader reads: address held stable by the link side until ack
      if (rf_req_p) begin
         nxt_st.rf_hold = reg_image(st_ff, lk_ff.addr, nv_busy_i, cfg_i.stretch_enable);
         nxt_st.rf_ack_tgl = !st_ff.rf_ack_tgl;
      end

      // clears first, so a same-cycle hardware set wins below
      if (host_status_rd || rf_status_rd) begin
         nxt_st.msg_read = 1'b0;
      end
      if (host_req_i.wr) begin
         case (host_req_i.addr)
            REG_WDT_LOW: nxt_st.wdt[7:0] = merge(st_ff.wdt[7:0], host_req_i.mask, host_req_i.wdata);
            REG_WDT_HIGH: nxt_st.wdt[15:8] = merge(st_ff.wdt[15:8], host_req_i.mask, host_req_i.wdata);
            REG_STATUS: begin
               if (host_req_i.mask[ST_HOST_OWNS] && !host_req_i.wdata[ST_HOST_OWNS]) begin
                  nxt_st.host_owns = 1'b0;
               end
               if (host_req_i.mask[ST_NV_ERR] && !host_req_i.wdata[ST_NV_ERR]) begin
                  nxt_st.nv_err = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (i2c_nomatch_i) begin
         nxt_st.host_owns = 1'b0;
      end
      // expiry mid-transaction waits for the transaction to finish
      if (wdt_expired && !i2c_busy_i) begin
         nxt_st.host_owns = 1'b0;
      end
      if (ev.access_end) begin
         nxt_st.reader_owns = 1'b0;
      end
      if (host_sram_read_i) begin
         nxt_st.ready_host = 1'b0;
      end
      if (ev.sram_read) begin
         nxt_st.ready_reader = 1'b0;
         nxt_st.consumed = st_ff.ready_reader;
      end
      if (host_sram_written_i || !cfg_i.pass_through) begin
         nxt_st.consumed = 1'b0;
      end

      // hardware sets
      if (ev.final_block_read) begin
         nxt_st.msg_read = 1'b1;
      end
      // host wins a tie when both sides start in the same cycle
      if (!st_ff.host_owns && !st_ff.reader_owns) begin
         if (host_access_i) begin
            nxt_st.host_owns = 1'b1;
         end else if (ev.access_begin) begin
            nxt_st.reader_owns = 1'b1;
         end
      end
      if (ev.sram_written) begin
         nxt_st.ready_host = 1'b1;
      end
      if (host_sram_written_i) begin
         nxt_st.ready_reader = 1'b1;
      end
      if (nv_hv_fail_i) begin
         nxt_st.nv_err = 1'b1;
      end

      // field-detect output
      if (cfg_i.pass_through) begin
         nxt_st.detect = nxt_st.ready_host || nxt_st.consumed;
      end else begin
         case (cfg_i.detect_release_select)
            OFF_FIELD: if (field_fall) nxt_st.detect = 1'b0;
            OFF_HALT: if (ev.halted) nxt_st.detect = 1'b0;
            OFF_LAST_BLOCK: if (ev.final_block_read) nxt_st.detect = 1'b0;
            default: ;
         endcase
         case (cfg_i.detect_assert_select)
            ON_FIELD: if (field_rise) nxt_st.detect = 1'b1;
            ON_FIRST_CMD: if (ev.first_cmd) nxt_st.detect = 1'b1;
            ON_SELECT: if (ev.selected) nxt_st.detect = 1'b1;
            default: ;
         endcase
         // without a field nothing can be signalled
         if (!st_ff.field_s2) begin
            nxt_st.detect = 1'b0;
         end
      end

      if (srst_i) begin
         nxt_st = '0;
         nxt_st.wdt = WDT_COUNT_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      st_ff <= nxt_st;
   end

   // ----------------------------------------------------------------
   // link-clock logic
   // ----------------------------------------------------------------
   always_comb begin
      nxt_lk = lk_ff;
      nxt_lk.valid = 1'b0;
      nxt_lk.evt_tgl = lk_ff.evt_tgl ^ rf_evt_i;
      // one read in flight; further requests are dropped until it returns
      if (rf_rd_i && !lk_ff.busy) begin
         nxt_lk.req_tgl = !lk_ff.req_tgl;
         nxt_lk.busy = 1'b1;
         nxt_lk.addr = rf_rd_addr_i;
      end
      if (rf_ack_p) begin
         nxt_lk.busy = 1'b0;
         nxt_lk.data = st_ff.rf_hold;
         nxt_lk.valid = 1'b1;
      end
      if (rf_srst_i) begin
         nxt_lk = '0;
      end
   end

   always_ff @(posedge rf_clk_i) begin
      lk_ff <= nxt_lk;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign fd_o = 1'b0;
   assign fd_oe_o = st_ff.detect;
   assign host_rd_data_o = st_ff.rd_data;
   assign host_rd_valid_o = st_ff.rd_valid;
   assign host_mem_grant_o = st_ff.host_owns;
   assign reader_mem_grant_o = st_ff.reader_owns;
   assign host_nv_allow_o = st_ff.host_owns && !nv_busy_i;
   assign reader_nv_allow_o = st_ff.reader_owns && !nv_busy_i;
   assign rf_rd_data_o = lk_ff.data;
   assign rf_rd_valid_o = lk_ff.valid;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_msg_set;
      @(posedge clk_i) disable iff (srst_i)
      ev.final_block_read |=> st_ff.msg_read ##1 (st_ff.msg_read || $past(host_status_rd || rf_status_rd));
   endproperty
   a_msg_set: assert property (p_msg_set) else $error("message read flag not set");

   property p_msg_clear;
      @(posedge clk_i) disable iff (srst_i)
      host_status_rd && !ev.final_block_read |=> !st_ff.msg_read;
   endproperty
   a_msg_clear: assert property (p_msg_clear) else $error("message read flag not cleared by read");

   property p_reader_rise;
      @(posedge clk_i) disable iff (srst_i)
      $rose(st_ff.reader_owns) |-> $past(ev.access_begin) && !$past(st_ff.host_owns);
   endproperty
   a_reader_rise: assert property (p_reader_rise) else $error("reader ownership without request");

   property p_err_sticky;
      @(posedge clk_i) disable iff (srst_i)
      st_ff.nv_err && !(host_req_i.wr && host_req_i.addr == REG_STATUS) |=> st_ff.nv_err;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("write error flag lost");

   property p_nv_block;
      @(posedge clk_i) disable iff (srst_i)
      nv_busy_i |-> !host_nv_allow_o && !reader_nv_allow_o;
   endproperty
   a_nv_block: assert property (p_nv_block) else $error("nonvolatile access while busy");

   property p_stretch_read;
      @(posedge clk_i) disable iff (srst_i)
      host_req_i.rd && host_req_i.addr == REG_STRETCH
         |=> host_rd_valid_o && host_rd_data_o == {7'h00, $past(cfg_i.stretch_enable)};
   endproperty
   a_stretch_read: assert property (p_stretch_read) else $error("stretch byte image wrong");

   property p_wdt_release;
      @(posedge clk_i) disable iff (srst_i)
      wdt_expired && !i2c_busy_i && !host_access_i |=> !st_ff.host_owns;
   endproperty
   a_wdt_release: assert property (p_wdt_release) else $error("expiry did not release host");

   property p_wdt_wait;
      @(posedge clk_i) disable iff (srst_i)
      wdt_expired && i2c_busy_i && st_ff.host_owns && !host_req_i.wr && !i2c_nomatch_i |=> st_ff.host_owns;
   endproperty
   a_wdt_wait: assert property (p_wdt_wait) else $error("host released mid-transaction");

   property p_nomatch;
      @(posedge clk_i) disable iff (srst_i)
      i2c_nomatch_i && st_ff.host_owns |=> !st_ff.host_owns;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("mismatch kept host ownership");

   property p_fcfs;
      @(posedge clk_i) disable iff (srst_i)
      host_access_i && !st_ff.host_owns && !st_ff.reader_owns |=> st_ff.host_owns && !st_ff.reader_owns;
   endproperty
   a_fcfs: assert property (p_fcfs) else $error("host not granted free memory");

   property p_field_flag;
      @(posedge clk_i) disable iff (srst_i)
      host_status_rd |=> host_rd_data_o[ST_FIELD] == $past(st_ff.field_q);
   endproperty
   a_field_flag: assert property (p_field_flag) else $error("field flag not shown");

   property p_rf_read;
      @(posedge rf_clk_i) disable iff (rf_srst_i)
      rf_ack_p |=> rf_rd_valid_o && !lk_ff.busy;
   endproperty
   a_rf_read: assert property (p_rf_read) else $error("reader read not returned");

endmodule // tag_arbiter
`default_nettype wire

// [rtl/tag_arb_pkg.sv]
// shared constants, encodings and carrier types of the tag arbitration block
package tag_arb_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int WDT_TICK_NS = 9430;
   localparam int WDT_TICK_CYCLES = WDT_TICK_NS / CLK_PERIOD_NS;
   localparam logic [15:0] WDT_COUNT_RESET = 16'h0848;

   // ----------------------------------------------------------------
   // session register indices on the host register port
   // ----------------------------------------------------------------
   localparam int REG_AW = 3;
   localparam logic [REG_AW-1:0] REG_WDT_LOW = 3'h0;
   localparam logic [REG_AW-1:0] REG_WDT_HIGH = 3'h1;
   localparam logic [REG_AW-1:0] REG_STRETCH = 3'h2;
   localparam logic [REG_AW-1:0] REG_STATUS = 3'h3;

   // ----------------------------------------------------------------
   // session_status and stretch byte bit positions
   // ----------------------------------------------------------------
   localparam int ST_MSG_READ = 7;
   localparam int ST_HOST_OWNS = 6;
   localparam int ST_READER_OWNS = 5;
   localparam int ST_READY_HOST = 4;
   localparam int ST_READY_READER = 3;
   localparam int ST_NV_ERR = 2;
   localparam int ST_NV_BUSY = 1;
   localparam int ST_FIELD = 0;
   localparam int STRETCH_BIT = 0;

   // ----------------------------------------------------------------
   // field-detect event selections
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ON_FIELD, ON_FIRST_CMD, ON_SELECT} detect_on_t;
   typedef enum logic [1:0] {OFF_FIELD, OFF_HALT, OFF_LAST_BLOCK} detect_off_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      detect_on_t detect_assert_select;
      detect_off_t detect_release_select;
      logic pass_through;
      logic stretch_enable;
   } cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_AW-1:0] addr;
      logic [7:0] mask;
      logic [7:0] wdata;
   } host_reg_req_t;

   // one-cycle pulses from the reader front end, on the link clock
   typedef struct packed {
      logic first_cmd;
      logic selected;
      logic halted;
      logic final_block_read;
      logic sram_written;
      logic sram_read;
      logic access_begin;
      logic access_end;
   } rf_evt_t;

endpackage

// [rtl/toggle_sync.sv]
// toggle-to-pulse crossing of event flags into a destination clock
`timescale 1ns/1ps
`default_nettype none
module toggle_sync #(
   parameter int W = 1
) (
   // destination clock
   input wire logic clk_i,
   input wire logic srst_i,
   // toggles from the source domain, pulses in this one
   input wire logic [W-1:0] tgl_i,
   output logic [W-1:0] pulse_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
   } sync_t;

   sync_t st_ff;
   sync_t nxt_st;

   always_comb begin
      nxt_st.s1 = tgl_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      if (srst_i) begin
         nxt_st = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st_ff <= nxt_st;
   end

   // s1 feeds only s2; the edge is taken between the settled stages
   assign pulse_o = st_ff.s2 ^ st_ff.s3;

endmodule // toggle_sync
`default_nettype wire

// [rtl/wdt_timer.sv]
// host ownership watchdog: tick prescaler and 16-bit tick counter
`timescale 1ns/1ps
`default_nettype none
module wdt_timer import tag_arb_pkg::*; #(
   parameter int TICK_CYCLES = WDT_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // control
   input wire logic restart_i,
   input wire logic run_i,
   input wire logic [15:0] limit_i,
   // status
   output logic expired_o
);

   localparam int PW = $clog2(TICK_CYCLES);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   typedef struct packed {
      logic [PW-1:0] pre;
      logic [15:0] ticks;
      logic started;
      logic expired;
   } wdt_t;

   wdt_t st_ff;
   wdt_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (srst_i || !run_i) begin
         nxt_st = '0;
      end else if (restart_i) begin
         nxt_st = '0;
         nxt_st.started = 1'b1;
      end else if (st_ff.started && !st_ff.expired) begin
         if (st_ff.pre == PRE_LAST) begin
            nxt_st.pre = '0;
            nxt_st.ticks = st_ff.ticks + 16'h0001;
            nxt_st.expired = ({1'b0, st_ff.ticks} + 17'h00001) >= {1'b0, limit_i};
         end else begin
            nxt_st.pre = st_ff.pre + PW'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      st_ff <= nxt_st;
   end

   assign expired_o = st_ff.expired;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_restart;
      run_i && restart_i && !srst_i;
   endsequence

   property p_wdt_stopped;
      @(posedge clk_i) disable iff (srst_i)
      !run_i |=> !expired_o && st_ff.ticks == 16'h0000;
   endproperty
   a_wdt_stopped: assert property (p_wdt_stopped) else $error("watchdog ran while held");

   property p_wdt_restart;
      @(posedge clk_i) disable iff (srst_i)
      s_restart |=> !expired_o && st_ff.started && st_ff.ticks == 16'h0000;
   endproperty
   a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog did not restart");

endmodule // wdt_timer
`default_nettype wire

// [tb/rf_reader_model.sv]
// reader front end model: event pulses and register reads on the link clock
`timescale 1ns/1ps
`default_nettype none
module rf_reader_model import tag_arb_pkg::*; (
   // link clock
   input wire logic rf_clk_i,
   // requests toward the block
   output var rf_evt_t evt_o,
   output logic rd_o,
   output logic [REG_AW-1:0] addr_o,
   // answers from the block
   input wire logic [7:0] rd_data_i,
   input wire logic rd_valid_i
);
   initial begin
      evt_o = '0;
      rd_o = 1'b0;
      addr_o = '0;
   end
   task automatic pulse(input rf_evt_t e);
      @(posedge rf_clk_i) evt_o <= e;
      @(posedge rf_clk_i) evt_o <= '0;
   endtask
   // one read in flight only; a released address shows its inverse
   task automatic rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge rf_clk_i) begin
         rd_o <= 1'b1;
         addr_o <= a;
      end
      @(posedge rf_clk_i) begin
         rd_o <= 1'b0;
         addr_o <= ~a;
      end
      repeat (12) begin
         @(posedge rf_clk_i);
         #1;
         if (rd_valid_i === 1'b1) d = rd_data_i;
      end
   endtask
endmodule // rf_reader_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the tag arbitration block
`timescale 1ns/1ps
`default_nettype none
module tb_top import tag_arb_pkg::*;;
   logic clk_i = 1'b0, rf_clk_i = 1'b0, srst_i = 1'b1, rf_srst_i = 1'b1, zero = 1'b0, nm = 1'b0, bz = 1'b0;
   logic field_sense_i = 1'b0, vcc_sense_i = 1'b1, i2c_start_i = 1'b0, host_access_i = 1'b0;
   logic nv_busy_i = 1'b0, nv_hv_fail_i = 1'b0, fd_oe_o, host_rd_valid_o, host_mem_grant_o, reader_mem_grant_o;
   logic rf_rd_i, rf_rd_valid_o;
   logic [REG_AW-1:0] rf_rd_addr_i;
   logic [7:0] host_rd_data_o, rf_rd_data_o, d;
   cfg_t cfg_i = '{ON_FIELD, OFF_FIELD, 1'b0, 1'b1};
   host_reg_req_t req = '0;
   rf_evt_t rf_evt_i;
   int mismatches = 0, n_tests = 0, n;

   initial forever #5 clk_i = ~clk_i;
   initial begin
      #3;
      forever #80 rf_clk_i = ~rf_clk_i;
   end

   tag_arbiter dut (.clk_i(clk_i), .srst_i(srst_i), .rf_clk_i(rf_clk_i), .rf_srst_i(rf_srst_i),
      .field_sense_i(field_sense_i), .vcc_sense_i(vcc_sense_i), .fd_o(), .fd_oe_o(fd_oe_o), .cfg_i(cfg_i),
      .host_req_i(req), .host_rd_data_o(host_rd_data_o), .host_rd_valid_o(host_rd_valid_o),
      .i2c_start_i(i2c_start_i), .i2c_busy_i(bz), .i2c_nomatch_i(nm), .host_access_i(host_access_i),
      .host_sram_written_i(zero), .host_sram_read_i(zero), .nv_busy_i(nv_busy_i), .nv_hv_fail_i(nv_hv_fail_i),
      .host_mem_grant_o(host_mem_grant_o), .reader_mem_grant_o(reader_mem_grant_o), .host_nv_allow_o(),
      .reader_nv_allow_o(), .rf_evt_i(rf_evt_i), .rf_rd_i(rf_rd_i), .rf_rd_addr_i(rf_rd_addr_i),
      .rf_rd_data_o(rf_rd_data_o), .rf_rd_valid_o(rf_rd_valid_o));
   rf_reader_model m (.rf_clk_i(rf_clk_i), .evt_o(rf_evt_i), .rd_o(rf_rd_i), .addr_o(rf_rd_addr_i),
      .rd_data_i(rf_rd_data_o), .rd_valid_i(rf_rd_valid_o));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] k, input logic [7:0] v);
      @(posedge clk_i) req <= '{1'b1, 1'b0, a, k, v};
      @(posedge clk_i) req <= '0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string s);
      @(posedge clk_i) req <= '{1'b0, 1'b1, a, 8'h00, 8'h00};
      @(posedge clk_i) req <= '0;
      #1;
      chk(s, e, host_rd_valid_o === 1'b1 ? host_rd_data_o : 8'hxx);
   endtask
   task automatic waitfor(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (s !== v) chk("wait", {7'h00, v}, {7'h00, s});
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd(REG_STATUS, 8'h00, "status");
      rd(REG_WDT_LOW, 8'h48, "wdt low");
      rd(REG_WDT_HIGH, 8'h08, "wdt high");
      wr(REG_STRETCH, 8'hff, 8'hfe);
      rd(REG_STRETCH, 8'h01, "stretch");
      rd(3'h7, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_msg();
      m.pulse('{final_block_read: 1'b1, default: 1'b0});
      repeat (20) @(posedge clk_i);
      rd(REG_STATUS, 8'h80, "msg set");
      rd(REG_STATUS, 8'h00, "msg cleared");
      $display("test message done");
   endtask
   task automatic t_own();
      @(posedge clk_i) host_access_i <= 1'b1;
      @(posedge clk_i) host_access_i <= 1'b0;
      waitfor(host_mem_grant_o, 1'b1);
      rd(REG_STATUS, 8'h40, "host owns");
      wr(REG_STATUS, 8'h40, 8'h00);
      rd(REG_STATUS, 8'h00, "host freed");
      @(posedge clk_i) host_access_i <= 1'b1;
      @(posedge clk_i) host_access_i <= 1'b0;
      @(posedge clk_i) nm <= 1'b1;
      @(posedge clk_i) nm <= 1'b0;
      waitfor(host_mem_grant_o, 1'b0);
      m.pulse('{access_begin: 1'b1, default: 1'b0});
      waitfor(reader_mem_grant_o, 1'b1);
      m.rd(REG_STATUS, d);
      chk("rf status", 8'h20, d);
      m.pulse('{access_end: 1'b1, default: 1'b0});
      waitfor(reader_mem_grant_o, 1'b0);
      $display("test ownership done");
   endtask
   task automatic t_nv();
      @(posedge clk_i) nv_hv_fail_i <= 1'b1;
      @(posedge clk_i) begin
         nv_hv_fail_i <= 1'b0;
         nv_busy_i <= 1'b1;
      end
      wr(REG_STATUS, 8'h04, 8'h04);
      rd(REG_STATUS, 8'h06, "nv err busy");
      wr(REG_STATUS, 8'h04, 8'h00);
      nv_busy_i <= 1'b0;
      rd(REG_STATUS, 8'h00, "nv cleared");
      $display("test nonvolatile done");
   endtask
   task automatic t_fd();
      @(posedge clk_i) field_sense_i <= 1'b1;
      waitfor(fd_oe_o, 1'b1);
      rd(REG_STATUS, 8'h01, "field");
      @(posedge clk_i) field_sense_i <= 1'b0;
      waitfor(fd_oe_o, 1'b0);
      chk("fd released", 8'h00, {7'h00, fd_oe_o});
      $display("test detect done");
   endtask
   task automatic t_wdt();
      wr(REG_WDT_LOW, 8'hff, 8'h01);
      wr(REG_WDT_HIGH, 8'hff, 8'h00);
      @(posedge clk_i) begin
         host_access_i <= 1'b1;
         i2c_start_i <= 1'b1;
      end
      @(posedge clk_i) begin
         host_access_i <= 1'b0;
         i2c_start_i <= 1'b0;
      end
      waitfor(host_mem_grant_o, 1'b1);
      waitfor(host_mem_grant_o, 1'b0);
      // one tick of the prescaler is 943 cycles
      chk("wdt span", 8'h01, {7'h00, n > 900 && n < 1000});
      @(posedge clk_i) bz <= 1'b1;
      @(posedge clk_i) host_access_i <= 1'b1;
      @(posedge clk_i) host_access_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk("wdt wait", 8'h01, {7'h00, host_mem_grant_o});
      @(posedge clk_i) bz <= 1'b0;
      $display("test watchdog done");
   endtask

   initial begin
      repeat (4) @(posedge rf_clk_i);
      rf_srst_i <= 1'b0;
   end
   initial begin
      #300us;
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      t_reset();
      t_msg();
      t_own();
      t_nv();
      t_fd();
      t_wdt();
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
